// >>> include/adc_host_params.svh
`ifndef ADC_HOST_PARAMS_SVH
`define ADC_HOST_PARAMS_SVH

// Control word reset value: normal power mode, channel 0
`define CTRL_RESET        12'h000
// Control word field positions
`define CTRL_MASK_NEXT    3
`define CTRL_PM_LSB       4
`define CTRL_CHAN_LSB     7
// Channel mask reset value
`define MASK_RESET        8'h00
// Conversion clock edge counts
`define TRACK_RISE_COUNT  4'hD
`define CONV_FALL_COUNT   4'hE
// Cycles between result push and busy release; one more than the
// output load so a live read shows the new word before busy falls
`define SETTLE_CYCLES     2'h3

`endif

// >>> include/adc_host_pkg.sv
package adc_host_pkg;

  // Power management field encodings
  typedef enum logic [1:0] {
    PM_NORMAL        = 2'b00,
    PM_AUTO_SHUTDOWN = 2'b01,
    PM_AUTO_STANDBY  = 2'b10,
    PM_FULL_SHUTDOWN = 2'b11
  } power_mode_t;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    CONV_IDLE    = 2'b00,
    CONV_RUN     = 2'b01,
    CONV_PUSH    = 2'b10,
    CONV_SETTLE  = 2'b11
  } conv_state_t;

endpackage

// >>> design/edge_detect.sv
`timescale 1ns/10ps
// Rise and fall pulses of a synchronous level
module edge_detect (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Level in, pulses out
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);

  typedef struct packed {
    logic prev;  // Level one cycle ago
  } edge_state_t;

  edge_state_t s_reg;
  edge_state_t s_next;

  // Next state: remember current level
  always_comb begin
    s_next      = s_reg;
    s_next.prev = level_i;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_reg.prev <= level_i;  // Track the pin so release gives no false edge
    end else begin
      s_reg <= s_next;
    end
  end

  assign rise_o = level_i & ~s_reg.prev;
  assign fall_o = ~level_i & s_reg.prev;

endmodule // edge_detect

// >>> design/result_fifo.sv
`timescale 1ns/10ps
// Small synchronous FIFO with valid/ready on both sides
module result_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST  = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULLC = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;    // Storage words
    logic [PW-1:0]               wr_ptr; // Next write slot
    logic [PW-1:0]               rd_ptr; // Oldest word
    logic [CW-1:0]               count;  // Words held
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic        do_wr;
  logic        do_rd;

  assign in_ready_o  = (s_reg.count != FULLC);
  assign out_valid_o = (s_reg.count != '0);
  assign out_data_o  = s_reg.mem[s_reg.rd_ptr];
  assign do_wr       = in_valid_i & in_ready_o;
  assign do_rd       = out_valid_o & out_ready_i;

  // Next state: write, read and occupancy
  always_comb begin
    s_next = s_reg;
    if (do_wr) begin
      s_next.mem[s_reg.wr_ptr] = in_data_i;
      s_next.wr_ptr = (s_reg.wr_ptr == LAST) ? '0 : s_reg.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      s_next.rd_ptr = (s_reg.rd_ptr == LAST) ? '0 : s_reg.rd_ptr + 1'b1;
    end
    if (do_wr && !do_rd) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (do_rd && !do_wr) begin
      s_next.count = s_reg.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule // result_fifo

// >>> design/adc_parallel_host_interface.sv
`timescale 1ns/10ps
module adc_parallel_host_interface
  import adc_host_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Strap: high for word mode, low for byte mode
  input  wire logic        word_mode_i,
  // Conversion control
  input  wire logic        conversion_start_n_i,
  input  wire logic        conversion_clock_i,
  // Analog core sample
  input  wire logic [11:0] sample_i,
  // Host bus strobes
  input  wire logic        chip_select_n_i,
  input  wire logic        read_n_i,
  input  wire logic        write_n_i,
  // Data lines; line 8 is data8_or_byte_select
  input  wire logic [11:0] data_in_i,
  output logic      [11:0] data_out_o,
  output logic      [11:0] data_oe_n_o,
  // Status
  output logic             busy_o,
  output logic             sampler_hold_o,
  output logic             shutdown_o,
  output logic             standby_o,
  // Register contents
  output logic      [11:0] control_o,
  output logic      [7:0]  channel_mask_o
);

  `include "adc_host_params.svh"

  // Whole block state
  typedef struct packed {
    conv_state_t state;      // Conversion sequencer
    logic        busy;       // Busy output
    logic        hold;       // Sampler in hold
    logic [3:0]  rise_cnt;   // Conversion clock rises
    logic [3:0]  fall_cnt;   // Conversion clock falls
    logic [1:0]  settle_cnt; // Cycles after push
    logic [11:0] sample;     // Captured sample
    logic [2:0]  chan;       // Channel being converted
    logic        down;       // Full power-down
    logic        standby;    // Standby, reference alive
    logic        full_down;  // Held down by mode 11
    logic [11:0] ctrl;       // Control register
    logic [7:0]  mask;       // Channel mask register
    logic        mask_pend;  // Next write goes to mask
    logic [7:0]  low_byte;   // Pending low write byte
    logic [11:0] wdata;      // Write data under strobe
    logic        rsel_hi;    // High byte chosen on read
    logic [14:0] result;     // Channel and result shown
    logic        fresh;      // Shown result not yet read
    logic [11:0] dout;       // Data lines driven
    logic [11:0] oe_n;       // Line enables, low drives
  } host_state_t;

  host_state_t s_reg;
  host_state_t s_next;

  // Strobe levels and edges
  logic        rd_act;
  logic        wr_act;
  logic        st_rise;
  logic        st_fall;
  logic        ck_rise;
  logic        ck_fall;
  logic        rd_end;
  logic        wr_end;
  // FIFO handshakes
  logic        push_valid;
  logic        push_ready;
  logic        pop_valid;
  logic        pop_ready;
  logic [14:0] pop_data;
  // Write decode helpers
  logic [11:0] new_ctrl;
  logic        commit;
  logic        read_done;

  // Chip select gates read and write internally
  assign rd_act = ~chip_select_n_i & ~read_n_i;
  assign wr_act = ~chip_select_n_i & ~write_n_i;

  edge_detect start_edge (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .level_i (conversion_start_n_i),
    .rise_o  (st_rise),
    .fall_o  (st_fall)
  );

  edge_detect clock_edge (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .level_i (conversion_clock_i),
    .rise_o  (ck_rise),
    .fall_o  (ck_fall)
  );

  edge_detect read_edge (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .level_i (rd_act),
    .rise_o  (),
    .fall_o  (rd_end)
  );

  edge_detect write_edge (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .level_i (wr_act),
    .rise_o  (),
    .fall_o  (wr_end)
  );

  // Results queue between the converter and the read port
  result_fifo #(.WIDTH(15), .DEPTH(FIFO_DEPTH)) results (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   ({s_reg.chan, s_reg.sample}),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data)
  );

  assign push_valid = (s_reg.state == CONV_PUSH);

  // A read is finished after word read or high byte read
  assign read_done = rd_end & (word_mode_i | s_reg.rsel_hi);

  // Output word may be replaced once read, or live in word mode
  assign pop_ready = ~s_reg.fresh | read_done | (rd_act & word_mode_i);

  // Assemble the control word from the write just released
  always_comb begin
    new_ctrl = s_reg.wdata;
    commit   = 1'b0;
    if (wr_end && !s_reg.mask_pend) begin
      if (word_mode_i) begin
        commit = 1'b1;
      end else if (s_reg.wdata[8]) begin
        new_ctrl = {s_reg.wdata[3:0], s_reg.low_byte};
        commit   = 1'b1;
      end
    end
  end

  // Next state of the whole block
  always_comb begin
    s_next = s_reg;

    // Latch write data and select while the strobe is low
    if (wr_act) begin
      s_next.wdata = data_in_i;
    end
    if (rd_act) begin
      s_next.rsel_hi = data_in_i[8];
    end

    // Conversion sequencer
    unique case (s_reg.state)
      CONV_IDLE: begin
        if (st_fall && !s_reg.down && !s_reg.standby && !s_reg.full_down) begin
          s_next.state    = CONV_RUN;
          s_next.busy     = 1'b1;
          s_next.hold     = 1'b1;
          s_next.rise_cnt = '0;
          s_next.fall_cnt = '0;
          s_next.sample   = sample_i;
          s_next.chan     = s_reg.ctrl[`CTRL_CHAN_LSB +: 3];
        end else if (st_rise && !s_reg.full_down) begin
          s_next.hold    = 1'b0;
          s_next.down    = 1'b0;
          s_next.standby = 1'b0;
        end
      end
      CONV_RUN: begin
        if (st_rise) begin
          s_next.state = CONV_IDLE;
          s_next.busy  = 1'b0;
          s_next.hold  = 1'b0;
        end else begin
          if (ck_rise) begin
            s_next.rise_cnt = s_reg.rise_cnt + 4'h1;
            if (s_reg.rise_cnt + 4'h1 == `TRACK_RISE_COUNT) begin
              s_next.hold = 1'b0;
            end
          end
          if (ck_fall) begin
            s_next.fall_cnt = s_reg.fall_cnt + 4'h1;
            if (s_reg.fall_cnt + 4'h1 == `CONV_FALL_COUNT) begin
              s_next.state = CONV_PUSH;
            end
          end
        end
      end
      CONV_PUSH: begin
        // Busy stays high while the queue is full
        if (push_ready) begin
          s_next.state      = CONV_SETTLE;
          s_next.settle_cnt = '0;
        end
      end
      CONV_SETTLE: begin
        s_next.settle_cnt = s_reg.settle_cnt + 2'h1;
        if (s_reg.settle_cnt + 2'h1 == `SETTLE_CYCLES) begin
          s_next.state = CONV_IDLE;
          s_next.busy  = 1'b0;
          unique case (power_mode_t'(s_reg.ctrl[`CTRL_PM_LSB +: 2]))
            PM_AUTO_SHUTDOWN: begin
              s_next.down = 1'b1;
              s_next.hold = 1'b1;
            end
            PM_AUTO_STANDBY: begin
              s_next.standby = 1'b1;
              s_next.hold    = 1'b1;
            end
            PM_NORMAL, PM_FULL_SHUTDOWN: begin
              s_next.down = s_reg.down;
            end
          endcase
        end
      end
    endcase

    // Register writes at strobe release
    if (wr_end) begin
      if (s_reg.mask_pend) begin
        s_next.mask      = s_reg.wdata[7:0];
        s_next.mask_pend = 1'b0;
      end else if (!word_mode_i && !s_reg.wdata[8]) begin
        s_next.low_byte = s_reg.wdata[7:0];
      end
    end
    if (commit) begin
      s_next.ctrl      = new_ctrl;
      s_next.mask_pend = new_ctrl[`CTRL_MASK_NEXT];
      if (power_mode_t'(new_ctrl[`CTRL_PM_LSB +: 2]) == PM_FULL_SHUTDOWN) begin
        s_next.full_down = 1'b1;
        s_next.down      = 1'b1;
        s_next.hold      = 1'b1;
      end else if (s_reg.full_down) begin
        s_next.full_down = 1'b0;
        s_next.down      = 1'b0;
        s_next.hold      = 1'b0;
      end
    end

    // Output word from the queue, or marked read
    if (pop_valid && pop_ready) begin
      s_next.result = pop_data;
      s_next.fresh  = 1'b1;
    end else if (read_done) begin
      s_next.fresh = 1'b0;
    end

    // Drive the data lines only while selected and read
    if (rd_act) begin
      if (word_mode_i) begin
        s_next.oe_n = 12'h000;
        s_next.dout = s_reg.result[11:0];
      end else begin
        s_next.oe_n = 12'hF00;
        if (data_in_i[8]) begin
          s_next.dout = {4'h0, 1'b0, s_reg.result[14:12], s_reg.result[11:8]};
        end else begin
          s_next.dout = {4'h0, s_reg.result[7:0]};
        end
      end
    end else begin
      s_next.oe_n = 12'hFFF;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_reg          <= '0;
      s_reg.state    <= CONV_IDLE;
      s_reg.hold     <= 1'b1;
      s_reg.ctrl     <= `CTRL_RESET;
      s_reg.mask     <= `MASK_RESET;
      s_reg.oe_n     <= 12'hFFF;
    end else begin
      s_reg <= s_next;
    end
  end

  assign data_out_o     = s_reg.dout;
  assign data_oe_n_o    = s_reg.oe_n;
  assign busy_o         = s_reg.busy;
  assign sampler_hold_o = s_reg.hold;
  assign shutdown_o     = s_reg.down;
  assign standby_o      = s_reg.standby;
  assign control_o      = s_reg.ctrl;
  assign channel_mask_o = s_reg.mask;

endmodule // adc_parallel_host_interface

// >>> dv/adc_host_props.sv
`timescale 1ns/10ps
// Timing checks on the host port of the converter
module adc_host_props (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        srst_i,
  // Strap, conversion control and strobes
  input wire logic        word_mode_i,
  input wire logic        conversion_start_n_i,
  input wire logic        conversion_clock_i,
  input wire logic        chip_select_n_i,
  input wire logic        read_n_i,
  input wire logic        write_n_i,
  input wire logic [11:0] data_in_i,
  // Device outputs
  input wire logic [11:0] data_out_o,
  input wire logic [11:0] data_oe_n_o,
  input wire logic        busy_o,
  input wire logic        sampler_hold_o,
  input wire logic        shutdown_o,
  input wire logic        standby_o,
  input wire logic [11:0] control_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic       ck_q_reg;  // Conversion clock one edge ago
  logic [1:0] pm_q_reg;  // Power field one edge ago
  logic [4:0] rise_reg;  // Conversion clock rises in this conversion
  logic [4:0] fall_reg;  // Conversion clock falls in this conversion
  // Count conversion clock edges while busy
  always_ff @(posedge clk_i) begin
    ck_q_reg <= conversion_clock_i;
    pm_q_reg <= control_o[5:4];
    if (srst_i || !busy_o) begin
      rise_reg <= 5'h00;
      fall_reg <= 5'h00;
    end else begin
      rise_reg <= rise_reg + 5'(conversion_clock_i && !ck_q_reg);
      fall_reg <= fall_reg + 5'(!conversion_clock_i && ck_q_reg);
    end
  end
  // Both read strobes active
  sequence s_read;
    !chip_select_n_i && !read_n_i;
  endsequence
  // Word write ending at the strobe release
  sequence s_word_write;
    !chip_select_n_i && !write_n_i && word_mode_i && !control_o[3] ##1
      (chip_select_n_i || write_n_i);
  endsequence
  a_start_sets_busy: assert property ($fell(conversion_start_n_i) && !busy_o && !shutdown_o
    && !standby_o && control_o[5:4] != 2'b11 |=> busy_o) else $error("busy missing");
  a_busy_stays_high: assert property (busy_o && !conversion_start_n_i
    && fall_reg < 5'h0D |=> busy_o) else $error("busy dropped early");
  a_early_abort: assert property (busy_o && $rose(conversion_start_n_i) && fall_reg < 5'h0D
    |-> ##[1:2] (!busy_o && !sampler_hold_o)) else $error("abort missing");
  a_busy_ends: assert property (busy_o && fall_reg == 5'h0E |-> ##[1:6] !busy_o)
    else $error("busy stuck");
  a_hold_on_start: assert property ($rose(busy_o) |-> sampler_hold_o)
    else $error("no hold");
  a_track_after_rise: assert property (busy_o && rise_reg == 5'h0D
    |-> ##[0:3] !sampler_hold_o) else $error("no track");
  a_read_word: assert property (s_read ##0 word_mode_i |=> data_oe_n_o == 12'h000)
    else $error("word drive");
  a_read_byte: assert property (s_read ##0 !word_mode_i |=> data_oe_n_o == 12'hF00)
    else $error("byte drive");
  a_bus_release: assert property (chip_select_n_i || read_n_i |=> data_oe_n_o == 12'hFFF)
    else $error("bus not released");
  a_live_read: assert property ($fell(busy_o) && !chip_select_n_i && !read_n_i && word_mode_i
    |-> data_oe_n_o == 12'h000 && $stable(data_out_o)) else $error("late result");
  a_word_write: assert property (s_word_write |=> control_o == $past(data_in_i, 2))
    else $error("write lost");
  a_auto_shut: assert property ($fell(busy_o) && control_o[5:4] == 2'b01
    |-> ##[0:1] (shutdown_o && sampler_hold_o)) else $error("no shutdown");
  a_auto_standby: assert property ($fell(busy_o) && control_o[5:4] == 2'b10
    |-> ##[0:1] (standby_o && sampler_hold_o)) else $error("no standby");
  a_full_down: assert property (control_o[5:4] == 2'b11 && pm_q_reg == 2'b11
    |-> shutdown_o && sampler_hold_o) else $error("not down");
  a_normal_up: assert property (control_o[5:4] == 2'b00 && pm_q_reg == 2'b00
    |-> !shutdown_o && !standby_o) else $error("not powered");
endmodule // adc_host_props

bind adc_parallel_host_interface adc_host_props i_adc_host_props (.*);

// >>> dv/host_model.sv
`timescale 1ns/10ps
// Bus master and conversion clock source facing the host port
module host_model (
  // Clock and device side
  input  wire logic        clk_i,
  input  wire logic        busy_i,
  input  wire logic [11:0] dout_i,
  input  wire logic [11:0] oe_n_i,
  // Strobes and conversion control
  output logic             start_n_o,
  output logic             conv_clk_o,
  output logic             cs_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  // Resolved data lines
  output logic      [11:0] bus_o
);
  logic [11:0] drv_reg;  // Host value on the lines
  logic        div_reg;  // Halves the conversion clock rate
  initial begin
    // Start idles low from power-up so the first rise leaves hold
    {start_n_o, cs_n_o, rd_n_o, wr_n_o} = 4'h7;
    {conv_clk_o, div_reg} = 2'h0;
    drv_reg = 12'h000;
  end
  // Device value where it drives, host value elsewhere
  assign bus_o = (~oe_n_i & dout_i) | (oe_n_i & drv_reg);
  // Conversion clock runs only while converting
  always @(posedge clk_i) begin
    div_reg <= busy_i & ~div_reg;
    if (!busy_i) conv_clk_o <= 1'b0;
    else if (div_reg) conv_clk_o <= ~conv_clk_o;
  end
  // Bounded wait for a busy level
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 300 && busy_i !== v; i++) @(negedge clk_i);
  endtask
  // Start rise, then acquisition time before any fall
  task automatic start_rise();
    @(negedge clk_i) start_n_o = 1'b1;
    repeat (2) @(negedge clk_i);
  endtask
  // Start held low until busy ends, past the 14th fall
  task automatic convert();
    start_rise();
    start_n_o = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask
  // Start raised n cycles into a conversion
  task automatic abort_after(input int n);
    start_rise();
    start_n_o = 1'b0;
    wait_busy(1'b1);
    repeat (n) @(negedge clk_i);
    start_n_o = 1'b1;
    repeat (2) @(negedge clk_i);
  endtask
  // One write access; released lines show the inverse
  task automatic write(input logic [11:0] d);
    @(negedge clk_i) {cs_n_o, wr_n_o, drv_reg} = {2'b00, d};
    @(negedge clk_i) {cs_n_o, wr_n_o, drv_reg} = {2'b11, ~d};
    repeat (2) @(negedge clk_i);
  endtask
  // One read access; hb picks the byte in byte mode
  task automatic read(input logic hb, output logic [11:0] q);
    @(negedge clk_i) {cs_n_o, rd_n_o} = 2'b00;
    drv_reg[8] = hb;
    repeat (2) @(negedge clk_i);
    q = dout_i;
    {cs_n_o, rd_n_o} = 2'b11;
    repeat (2) @(negedge clk_i);
  endtask
  // Read strobes held low or released
  task automatic hold_read(input logic on);
    @(negedge clk_i) {cs_n_o, rd_n_o} = {2{~on}};
  endtask
endmodule // host_model

// >>> dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        clk = 1'b0;  // 10 MHz clock
  logic        srst;        // Synchronous reset
  logic        word_mode;   // Width strap
  logic [11:0] sample;      // Analog core result
  logic        start_n, conv_clk, cs_n, rd_n, wr_n;
  logic [11:0] bus, dout, oe_n, control;
  logic        busy, hold, shutdown, standby;
  logic [7:0]  mask;
  int          fail_count = 0;
  int          cmp_count = 0;
  // Clock
  always #50 clk = ~clk;
  adc_parallel_host_interface #(.FIFO_DEPTH(4)) i_adc_parallel_host_interface (
    .clk_i(clk), .srst_i(srst), .word_mode_i(word_mode),
    .conversion_start_n_i(start_n), .conversion_clock_i(conv_clk), .sample_i(sample),
    .chip_select_n_i(cs_n), .read_n_i(rd_n), .write_n_i(wr_n), .data_in_i(bus),
    .data_out_o(dout), .data_oe_n_o(oe_n), .busy_o(busy), .sampler_hold_o(hold),
    .shutdown_o(shutdown), .standby_o(standby), .control_o(control),
    .channel_mask_o(mask));
  host_model i_host_model (
    .clk_i(clk), .busy_i(busy), .dout_i(dout), .oe_n_i(oe_n), .start_n_o(start_n),
    .conv_clk_o(conv_clk), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .bus_o(bus));
  // Compare and count
  task automatic compare(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Conversion, then read back one word or two bytes
  task automatic conv_read(input logic [11:0] s, input logic [11:0] lo, input logic [11:0] hi);
    logic [11:0] q;
    sample = s;
    i_host_model.convert();
    i_host_model.read(1'b0, q);
    compare(word_mode ? q : {4'h0, q[7:0]}, lo);
    if (!word_mode) begin
      i_host_model.read(1'b1, q);
      compare({4'h0, q[7:0]}, hi);
    end
  endtask
  // Watchdog
  initial begin
    #1000000;
    fail_count++;
    results();
  end
  // Main sequence
  initial begin
    srst = 1'b1;
    word_mode = 1'b1;
    sample = 12'h000;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    compare(12'({busy, shutdown, standby}), 12'h000);
    compare(oe_n, 12'hFFF);
    compare(control, 12'h000);
    compare({4'h0, mask}, 12'h000);
    compare(12'(hold), 12'h001);
    i_host_model.start_rise();
    compare(12'(hold), 12'h000);
    i_host_model.write(12'h080);
    compare(control, 12'h080);
    conv_read(12'h9C3, 12'h9C3, 12'h000);
    sample = 12'h3E7;
    i_host_model.hold_read(1'b1);
    i_host_model.convert();
    compare(dout, 12'h3E7);
    i_host_model.hold_read(1'b0);
    sample = 12'h111;
    i_host_model.abort_after(12);
    compare(12'({busy, hold}), 12'h000);
    conv_read(12'h5A6, 12'h5A6, 12'h000);
    i_host_model.write(12'h008);
    i_host_model.write(12'h05A);
    compare({4'h0, mask}, 12'h05A);
    i_host_model.write(12'h010);
    conv_read(12'h222, 12'h222, 12'h000);
    compare(12'({shutdown, hold}), 12'h003);
    i_host_model.start_rise();
    compare(12'(shutdown), 12'h000);
    i_host_model.write(12'h020);
    conv_read(12'h333, 12'h333, 12'h000);
    compare(12'({standby, hold}), 12'h003);
    i_host_model.start_rise();
    compare(12'(standby), 12'h000);
    i_host_model.write(12'h030);
    i_host_model.convert();
    compare(12'({busy, shutdown}), 12'h001);
    i_host_model.write(12'h000);
    compare(12'(shutdown), 12'h000);
    word_mode = 1'b0;
    i_host_model.write(12'h080);
    compare(control, 12'h000);
    i_host_model.write(12'h102);
    compare(control, 12'h280);
    conv_read(12'hA5C, 12'h05C, 12'h05A);
    i_host_model.write(12'h008);
    i_host_model.write(12'h100);
    i_host_model.write(12'h0C3);
    compare({4'h0, mask}, 12'h0C3);
    // Second reset in mid-run
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    compare(control, 12'h000);
    compare({4'h0, mask}, 12'h000);
    compare(12'({busy, hold, shutdown}), 12'h002);
    compare(oe_n, 12'hFFF);
    results();
  end
endmodule // testbench
